// *** logic/ccd_pkg.sv ***
// shared constants and types for the frame transfer sensor readout sequencer
package ccd_pkg;

  // ==========================================================
  // array geometry
  localparam int unsigned ACT_LINES = 1002;     // image lines
  localparam int unsigned ACT_PIXELS = 1004;    // pixels per line
  localparam int unsigned DARK_LEFT = 28;       // shielded columns, left edge
  localparam int unsigned DARK_RIGHT = 4;       // shielded columns, right edge
  localparam int unsigned ISO_LINES = 6;        // dark isolation lines
  localparam int unsigned XFER_LINES = ACT_LINES + ISO_LINES;
  localparam int unsigned BAD_LINES = 2;        // lines lost to the long register
  localparam int unsigned GAIN_STAGES = 400;    // multiplication stages
  localparam int unsigned DUMMY_PIXELS = 16;    // transport pixels, arbitrary
  localparam int unsigned SER_LEN = 2 * ACT_PIXELS;

  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CLEAR_MIN_US = 100;   // least drain clearing pulse
  localparam int unsigned CLEAR_MIN_CYC = CLEAR_MIN_US * CLK_MHZ;
  localparam int unsigned US_CYC = CLK_MHZ;     // cycles per microsecond tick
  localparam int unsigned FRAME_RATE = 30;      // frames per second
  localparam int unsigned FRAME_US = 1000000 / FRAME_RATE;
  localparam int unsigned EXPO_MAX_US = 33333;  // one thirtieth of a second
  localparam int unsigned EXPO_MIN_US = 200;    // one five-thousandth

  // ==========================================================
  // word widths and reset values
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LINE_W = 11;
  localparam int unsigned COL_W = 12;
  localparam int unsigned GAIN_W = 8;
  localparam int unsigned WORD_W = DATA_W + LINE_W + COL_W + 2;
  localparam logic [15:0] EXPO_RST = 16'h0000;
  localparam logic [15:0] DARK_LEVEL = 16'h0040;
  localparam int unsigned EXPO_SHIFT = 2;

  // ==========================================================
  // pin indices within the synchronised gate vector
  localparam int unsigned PIN_IMG_A = 0;
  localparam int unsigned PIN_IMG_B = 1;
  localparam int unsigned PIN_STO_A = 2;
  localparam int unsigned PIN_STO_B = 3;
  localparam int unsigned PIN_SER_A = 4;
  localparam int unsigned PIN_SER_B = 5;
  localparam int unsigned PIN_GAIN = 6;
  localparam int unsigned PIN_NODE = 7;
  localparam int unsigned PIN_DRAIN = 8;
  localparam int unsigned PIN_N = 9;

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_INTEG = 2'b01,
    ST_XFER = 2'b10
  } ccd_state_e;

endpackage : ccd_pkg

// *** logic/ccd_skid_buf.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module ccd_skid_buf #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } ccd_buf_s;

  ccd_buf_s st_r;
  ccd_buf_s st_nxt;
  logic do_wr;
  logic do_rd;

  // honest flags straight from the fill count
  assign in_ready = (st_r.count != (PW + 1)'(DEPTH));
  assign out_valid = (st_r.count != '0);
  assign out_data = st_r.mem[st_r.rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (do_wr) begin
      st_nxt.mem[st_r.wr_ptr] = in_data;
      st_nxt.wr_ptr = (st_r.wr_ptr == PW'(DEPTH - 1)) ? '0 : st_r.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      st_nxt.rd_ptr = (st_r.rd_ptr == PW'(DEPTH - 1)) ? '0 : st_r.rd_ptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (do_rd && !do_wr) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : ccd_skid_buf

// *** logic/ccd_readout_seq.sv ***
// frame transfer sensor readout sequencer: gate clocks in, sampled pixel words out
`timescale 1ns/1ns

// Summary of operation
// R1: array holds 1002 lines of 1004 pixels
// R2: 28 left, 4 right dark columns
// R3: six isolation lines move with frame transfer
// R4: drain clear held at least 100 us
// R5: end of clearing pulse starts integration
// R6: exposure ranges from 1/30 to 1/5000 s
// R7: fast transfer, stored frame read next cycle
// R8: lines leave storage one at a time
// R9: double register, 400 gain stages, dummies
// R10: first two lines of each scan invalid
// R11: gain follows gain gate pulse amplitude
// R12: one node clear pulse per pixel
// R13: skipped node clears sum packets
// R14: timing supports 30 frames per second
// R15: dark pixels restore black level downstream
// R16: downstream correlated double sampling recommended
// R17: image and storage gates at 1 MHz
// R18: serial, gain, node clear at 35 MHz
// R19: transfer clocks image and storage together
// R20: full serial length clocked per line
module ccd_readout_seq #(
  parameter int unsigned CLEAR_MIN_CYC = ccd_pkg::CLEAR_MIN_CYC,
  parameter int unsigned DUMMY_PIXELS = ccd_pkg::DUMMY_PIXELS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // gate clocks from the timing generator
  input wire logic image_gate_phase_a,
  input wire logic image_gate_phase_b,
  input wire logic storage_gate_phase_a,
  input wire logic storage_gate_phase_b,
  input wire logic serial_gate_phase_a,
  input wire logic serial_gate_phase_b,
  input wire logic gain_gate_pulse,
  input wire logic node_clear_pulse,
  input wire logic antibloom_drain,
  // multiplication pulse amplitude code
  input wire logic [ccd_pkg::GAIN_W-1:0] gain_level,
  // pixel stream
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [ccd_pkg::DATA_W-1:0] pix_data,
  output logic [ccd_pkg::LINE_W-1:0] pix_line,
  output logic [ccd_pkg::COL_W-1:0] pix_col,
  output logic pix_dark,
  output logic pix_invalid,
  // status
  output logic frame_stored,
  output logic integrating,
  output logic sample_overrun
);
  import ccd_pkg::*;

  // ==========================================================
  // state
  // every flop of the block outside the output buffer sits in this one record, the pin synchronisers
  // included, so a single reset loads them all in the same cycle
  typedef struct packed {
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic [PIN_N-1:0] prev;
    ccd_state_e state;
    logic [5:0] tick_cnt;
    logic [15:0] expo_us;
    logic [15:0] clr_cnt;
    logic [LINE_W-1:0] xfer_lines;
    logic [15:0] stored_expo;
    logic frame_ready;
    logic [LINE_W-1:0] line_idx;
    logic [COL_W-1:0] col;
    logic gain_seen;
    logic [DATA_W-1:0] node_acc;
    logic [COL_W-1:0] node_col;
    logic node_dark;
    logic push_valid;
    logic [WORD_W-1:0] push_word;
    logic overrun;
  } ccd_seq_s;

  ccd_seq_s st_r;
  ccd_seq_s st_nxt;

  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] rise;
  logic drain_fall;
  logic push_ready;
  logic [WORD_W-1:0] pop_word;
  logic line_bad;
  logic [DATA_W-1:0] packet;
  logic [DATA_W+GAIN_W-1:0] gained;
  logic [DATA_W:0] acc_sum;
  logic ser_step;
  logic [DATA_W-1:0] sat_packet;

  // shielded columns at both edges of every line
  function automatic logic is_dark(input logic [COL_W-1:0] c);
    is_dark = (c < COL_W'(DARK_LEFT)) ||
      ((c >= COL_W'(ACT_PIXELS - DARK_RIGHT)) && (c < COL_W'(ACT_PIXELS))); // [R2]
  endfunction : is_dark

  // clip a wide value to the data width instead of letting it wrap to a dark level
  function automatic logic [DATA_W-1:0] clip(input logic [DATA_W+GAIN_W-1:0] v);
    clip = (v[DATA_W+GAIN_W-1:DATA_W] != '0) ? {DATA_W{1'b1}} : v[DATA_W-1:0];
  endfunction : clip

  // ==========================================================
  // pin gathering and edge detection
  assign pins = {antibloom_drain, node_clear_pulse, gain_gate_pulse, serial_gate_phase_b,
    serial_gate_phase_a, storage_gate_phase_b, storage_gate_phase_a, image_gate_phase_b,
    image_gate_phase_a};
  // edges come only from the second stage, never the first
  // limitation: a pin already high as reset ends reads as a rising edge
  assign rise = st_r.sync2 & ~st_r.prev;
  assign drain_fall = st_r.prev[PIN_DRAIN] & ~st_r.sync2[PIN_DRAIN];

  // lines lost while the long register fills, or no frame yet stored
  assign line_bad = !st_r.frame_ready || (st_r.line_idx <= LINE_W'(BAD_LINES)); // [R10]

  // charge packet arriving at the detection node for the current column
  // lit cells carry the stored exposure as a stand-in for collected charge
  always_comb begin
    packet = '0;
    if (st_r.col >= COL_W'(ACT_PIXELS)) begin
      packet = '0; // dummy and empty register cells carry no charge [R9]
    end else if (is_dark(st_r.col)) begin
      packet = DARK_LEVEL; // black reference for downstream clamping [R15]
    end else if (!line_bad) begin
      packet = st_r.stored_expo >> EXPO_SHIFT;
    end
    // gain scales with the pulse amplitude only when the gain gate was clocked [R11]
    gained = st_r.gain_seen ? (DATA_W + GAIN_W)'(packet) * (DATA_W + GAIN_W)'(gain_level)
                            : (DATA_W + GAIN_W)'(packet);
  end

  // saturating node accumulation; limited to the data width
  assign sat_packet = clip(gained);
  assign acc_sum = (DATA_W + 1)'(st_r.node_acc) + (DATA_W + 1)'(sat_packet);

  // a serial step that delivers one more cell to the detection node [R9] [R20]
  assign ser_step = (st_r.state == ST_INTEG) && rise[PIN_SER_B] &&
    (st_r.col != COL_W'(SER_LEN + DUMMY_PIXELS));

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    st_nxt.overrun = 1'b0;

    // microsecond tick from the core clock divider
    // exposure is kept in whole microseconds; finer placement of the frame transfer end is lost
    if (st_r.tick_cnt == 6'(US_CYC - 1)) begin
      st_nxt.tick_cnt = '0;
      if (st_r.expo_us != 16'hFFFF) begin
        st_nxt.expo_us = st_r.expo_us + 16'h0001; // range 1/5000 to 1/30 s fits [R6]
      end
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 6'h01;
    end

    // drain clearing pulse width, only a full-length pulse empties the wells
    // a short pulse leaves charge behind, so it does not restart the exposure
    if (st_r.sync2[PIN_DRAIN]) begin
      if (st_r.clr_cnt != 16'hFFFF) begin
        st_nxt.clr_cnt = st_r.clr_cnt + 16'h0001;
      end
    end else begin
      st_nxt.clr_cnt = '0;
    end
    if (drain_fall && (st_r.clr_cnt >= 16'(CLEAR_MIN_CYC))) begin // [R4]
      st_nxt.expo_us = EXPO_RST; // falling edge opens a fresh exposure [R5]
      st_nxt.tick_cnt = '0;
    end

    // frame transfer tracking; readout below only runs while integrating
    case (st_r.state)
      ST_INTEG: begin
        // the first image gate step ends integration
        if (rise[PIN_IMG_B]) begin
          st_nxt.state = ST_XFER;
          st_nxt.xfer_lines = LINE_W'(1);
        end
      end
      ST_XFER: begin
        // image and storage step together; isolation lines ride along [R3] [R19]
        if (rise[PIN_IMG_B]) begin
          st_nxt.xfer_lines = st_r.xfer_lines + 1'b1;
        end
        // checked a cycle after the last step, so that step is still counted
        if (st_r.xfer_lines == LINE_W'(XFER_LINES)) begin // [R1] [R7]
          st_nxt.state = ST_INTEG;
          st_nxt.stored_expo = st_r.expo_us;
          st_nxt.frame_ready = 1'b1;
          st_nxt.line_idx = '0;
          st_nxt.col = COL_W'(SER_LEN + DUMMY_PIXELS);
          st_nxt.expo_us = EXPO_RST;
        end
      end
      default: begin
        st_nxt.state = ST_INTEG;
      end
    endcase

    // readout of the stored frame runs during the next integration [R7]
    // serial and storage pins are ignored during transfer, where a step would smear
    if (st_r.state == ST_INTEG) begin
      // storage-only step moves exactly one line into the serial register [R8]
      if (rise[PIN_STO_B] && !rise[PIN_IMG_B]) begin
        if (st_r.line_idx != LINE_W'(XFER_LINES + BAD_LINES)) begin
          st_nxt.line_idx = st_r.line_idx + 1'b1;
        end else begin
          st_nxt.frame_ready = 1'b0; // whole frame drained
        end
        st_nxt.col = '0;
        st_nxt.gain_seen = 1'b0;
      end
      if (rise[PIN_GAIN]) begin
        st_nxt.gain_seen = 1'b1;
      end
      // every serial step through the double-length register delivers a cell [R9] [R20]
      if (ser_step) begin
        st_nxt.col = st_r.col + 1'b1;
        st_nxt.node_acc = clip((DATA_W + GAIN_W)'(acc_sum));
        st_nxt.node_col = st_r.col;
        st_nxt.node_dark = is_dark(st_r.col);
      end
    end

    // handing the word to the buffer
    // cleared before the set below, so a fresh sample in the same cycle wins
    if (st_r.push_valid && push_ready) begin
      st_nxt.push_valid = 1'b0;
    end
    // node clear samples and empties the node; skipped clears sum packets [R12] [R13]
    if (rise[PIN_NODE]) begin
      if (st_r.push_valid && !push_ready) begin
        st_nxt.overrun = 1'b1; // receiver stalled past both buffer entries
      end else begin
        st_nxt.push_valid = 1'b1;
        st_nxt.push_word = {st_r.node_acc, st_r.line_idx, st_r.node_col, st_r.node_dark, line_bad};
      end
      // a cell landing in the same cycle opens the next sum instead of being lost
      if (ser_step) begin
        st_nxt.node_acc = sat_packet;
      end else begin
        st_nxt.node_acc = '0;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.state <= ST_INTEG;
      st_r.expo_us <= EXPO_RST;
      // column parked past the register end, so stray serial steps do nothing
      st_r.col <= COL_W'(SER_LEN + DUMMY_PIXELS);
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // output buffer: one sample per node clear keeps pace with a 30 frame/s scan [R14]
  // two entries plus the push register ride out a stall of three pixel periods
  ccd_skid_buf #(
    .WIDTH(WORD_W),
    .DEPTH(2)
  ) u_buf (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(st_r.push_valid),
    .in_ready(push_ready),
    .in_data(st_r.push_word),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(pop_word)
  );

  // ==========================================================
  // word fields and status
  // field order must match the packing at the push register
  assign pix_data = pop_word[WORD_W-1 -: DATA_W];
  assign pix_line = pop_word[COL_W+2 +: LINE_W];
  assign pix_col = pop_word[2 +: COL_W];
  assign pix_dark = pop_word[1];
  assign pix_invalid = pop_word[0]; // [R10]
  assign frame_stored = st_r.frame_ready;
  assign integrating = (st_r.state == ST_INTEG);
  assign sample_overrun = st_r.overrun;

endmodule : ccd_readout_seq

// *** tb/ccd_readout_seq_chk.sv ***
// port checker for the readout sequencer
`timescale 1ns/1ns
module ccd_readout_seq_chk #(
  parameter int unsigned CLEAR_MIN_CYC = ccd_pkg::CLEAR_MIN_CYC,
  parameter int unsigned DUMMY_PIXELS = ccd_pkg::DUMMY_PIXELS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // watched pins
  input wire logic image_gate_phase_b,
  input wire logic node_clear_pulse,
  // pixel stream
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [ccd_pkg::DATA_W-1:0] pix_data,
  input wire logic [ccd_pkg::LINE_W-1:0] pix_line,
  input wire logic [ccd_pkg::COL_W-1:0] pix_col,
  input wire logic pix_dark,
  input wire logic pix_invalid,
  // status
  input wire logic frame_stored,
  input wire logic integrating,
  input wire logic sample_overrun
);
  import ccd_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // image step count, restarted each time integration resumes
  logic [10:0] img_cnt_r;
  logic img_q_r;
  logic int_q_r;
  always_ff @(posedge core_clk) begin
    img_q_r <= image_gate_phase_b;
    int_q_r <= integrating;
    if (srst || (integrating && !int_q_r)) begin
      img_cnt_r <= 11'h000;
    end else if (image_gate_phase_b && !img_q_r) begin
      img_cnt_r <= img_cnt_r + 11'h001;
    end
  end

  // ==========================================================
  // pin edges reach the core after two sync flops
  sequence s_word_out;
    ##4 pix_valid;
  endsequence
  sequence s_xfer_begin;
    ##[3:4] !integrating;
  endsequence

  AST_NODE_WORD: assert property ($rose(node_clear_pulse) && !pix_valid |-> s_word_out)
    else $error("no pixel word after node clear");
  AST_WORD_HOLD: assert property (pix_valid && !pix_ready |=>
    pix_valid && $stable({pix_data, pix_line, pix_col, pix_dark, pix_invalid}))
    else $error("stalled pixel word changed");
  AST_DARK_COLS: assert property (pix_valid |->
    pix_dark == (pix_col < 12'h01C || (pix_col >= 12'h3E8 && pix_col <= 12'h3EB)))
    else $error("dark flag does not match column");
  AST_BAD_LINES: assert property (pix_valid && pix_line <= 11'h002 |-> pix_invalid)
    else $error("early line not flagged invalid");
  AST_XFER_START: assert property ($rose(image_gate_phase_b) && integrating |-> s_xfer_begin)
    else $error("transfer did not start");
  AST_XFER_LINES: assert property ($rose(integrating) |-> img_cnt_r == 11'(XFER_LINES))
    else $error("transfer ended on wrong step count");
  AST_FRAME_STORED: assert property ($rose(integrating) |-> ##[0:1] frame_stored)
    else $error("frame not marked stored");
  AST_OVERRUN: assert property (sample_overrun |-> $past(pix_valid) ##1 !sample_overrun)
    else $error("overrun pulse without full buffer");
  AST_RESET_STATE: assert property ($past(srst) |-> !pix_valid && integrating && !frame_stored)
    else $error("wrong state after reset");
endmodule : ccd_readout_seq_chk

// *** tb/ccd_timing_gen.sv ***
// partner model: timing generator driving the gate clock pins
`timescale 1ns/1ns
module ccd_timing_gen (
  // clock
  input wire logic core_clk,
  // gate clock pins
  output logic image_gate_phase_a,
  output logic image_gate_phase_b,
  output logic storage_gate_phase_a,
  output logic storage_gate_phase_b,
  output logic serial_gate_phase_a,
  output logic serial_gate_phase_b,
  output logic gain_gate_pulse,
  output logic node_clear_pulse,
  output logic antibloom_drain
);
  import ccd_pkg::*;

  // ==========================================================
  // pin vector; phases held two cycles since the core may miss narrower ones
  logic [PIN_N-1:0] pins_r = '0;
  assign image_gate_phase_a = pins_r[PIN_IMG_A];
  assign image_gate_phase_b = pins_r[PIN_IMG_B];
  assign storage_gate_phase_a = pins_r[PIN_STO_A];
  assign storage_gate_phase_b = pins_r[PIN_STO_B];
  assign serial_gate_phase_a = pins_r[PIN_SER_A];
  assign serial_gate_phase_b = pins_r[PIN_SER_B];
  assign gain_gate_pulse = pins_r[PIN_GAIN];
  assign node_clear_pulse = pins_r[PIN_NODE];
  assign antibloom_drain = pins_r[PIN_DRAIN];

  function automatic logic [PIN_N-1:0] m(input int i);
    return (PIN_N)'(1) << i;
  endfunction : m
  task automatic drive(input logic [PIN_N-1:0] v, input int n);
    @(posedge core_clk);
    pins_r <= v;
    repeat (n - 1) @(posedge core_clk);
  endtask : drive
  // two-phase step, phase b rising mid-step
  task automatic step(input logic [PIN_N-1:0] a, input logic [PIN_N-1:0] b);
    drive(pins_r | a, 2);
    drive((pins_r & ~a) | b, 2);
    drive(pins_r & ~b, 2);
  endtask : step
  task automatic pulse(input int i);
    drive(pins_r | m(i), 2);
    drive(pins_r & ~m(i), 2);
  endtask : pulse
  // drain high for n cycles; the falling edge opens the exposure
  task automatic clear_pulse(input int n);
    drive(pins_r | m(PIN_DRAIN), n);
    drive(pins_r & ~m(PIN_DRAIN), 2);
  endtask : clear_pulse
  // image and storage stepped together, serial register idle
  task automatic frame_xfer();
    repeat (XFER_LINES) step(m(PIN_IMG_A) | m(PIN_STO_A), m(PIN_IMG_B) | m(PIN_STO_B));
  endtask : frame_xfer
  task automatic line_shift();
    step(m(PIN_STO_A), m(PIN_STO_B));
  endtask : line_shift
  // n serial steps, a node clear after each unless summing
  task automatic serial(input int n, input bit clr);
    repeat (n) begin
      step(m(PIN_SER_A), m(PIN_SER_B));
      if (clr) pulse(PIN_NODE);
    end
  endtask : serial
endmodule : ccd_timing_gen

// *** tb/tb_ccd_readout_seq.sv ***
// self-checking bench for the readout sequencer
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
  $display("unexpected %s: expected %h, seen %h", nm, ex, got); end end
module tb_ccd_readout_seq;
  import ccd_pkg::*;

  // ==========================================================
  // bench signals
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic pix_ready = 1'b1;
  logic [GAIN_W-1:0] gain_level = 8'h01;
  logic ia, ib, sa, sb, ra, rb, gp, nc, ad;
  logic pix_valid, pix_dark, pix_invalid, frame_stored, integrating, sample_overrun;
  logic [DATA_W-1:0] pix_data;
  logic [LINE_W-1:0] pix_line;
  logic [COL_W-1:0] pix_col;
  logic [WORD_W-1:0] wq[$];
  logic [WORD_W-1:0] w;
  int fails = 0;
  int cmp_count = 0;
  int ovr_cnt = 0;

  ccd_timing_gen u_ccd_timing_gen (.core_clk(core_clk), .image_gate_phase_a(ia), .image_gate_phase_b(ib),
    .storage_gate_phase_a(sa), .storage_gate_phase_b(sb), .serial_gate_phase_a(ra), .serial_gate_phase_b(rb),
    .gain_gate_pulse(gp), .node_clear_pulse(nc), .antibloom_drain(ad));
  // short clearing minimum keeps the run brief
  ccd_readout_seq #(.CLEAR_MIN_CYC(20), .DUMMY_PIXELS(16)) u_ccd_readout_seq (.core_clk(core_clk), .srst(srst),
    .image_gate_phase_a(ia), .image_gate_phase_b(ib), .storage_gate_phase_a(sa), .storage_gate_phase_b(sb),
    .serial_gate_phase_a(ra), .serial_gate_phase_b(rb), .gain_gate_pulse(gp), .node_clear_pulse(nc),
    .antibloom_drain(ad), .gain_level(gain_level), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_data(pix_data), .pix_line(pix_line), .pix_col(pix_col), .pix_dark(pix_dark), .pix_invalid(pix_invalid),
    .frame_stored(frame_stored), .integrating(integrating), .sample_overrun(sample_overrun));

  // ==========================================================
  // clock and word monitor; reads pre-edge values, so no race with the design
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1) wq.push_back({pix_invalid, pix_dark, pix_col, pix_line, pix_data});
    if (sample_overrun === 1'b1) ovr_cnt++;
  end

  task automatic stop_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk_word(input logic [15:0] d, input logic [10:0] ln, input logic [11:0] c, input logic dk,
    input logic iv);
    int i;
    for (i = 0; i < 400 && wq.size() == 0; i++) @(posedge core_clk);
    if (wq.size() == 0) begin
      fails++;
      stop_test();
    end else begin
      w = wq.pop_front();
      `CHK("pixel word", {iv, dk, c, ln, d}, w)
    end
  endtask : chk_word

  // ==========================================================
  // scenarios
  task automatic t_reset();
    `CHK("integrating", 1'b1, integrating)
    `CHK("frame_stored", 1'b0, frame_stored)
    `CHK("pix_valid", 1'b0, pix_valid)
  endtask : t_reset
  task automatic t_frame();
    u_ccd_timing_gen.clear_pulse(25);
    u_ccd_timing_gen.frame_xfer();
    repeat (6) @(posedge core_clk);
    `CHK("integrating", 1'b1, integrating)
    `CHK("frame_stored", 1'b1, frame_stored)
  endtask : t_frame
  task automatic t_bad_lines();
    int ln;
    for (ln = 1; ln <= 2; ln++) begin
      u_ccd_timing_gen.line_shift();
      u_ccd_timing_gen.serial(1, 1'b1);
      chk_word(DARK_LEVEL, ln[10:0], 12'h000, 1'b1, 1'b1);
    end
  endtask : t_bad_lines
  task automatic t_gain_sum();
    int i;
    @(posedge core_clk);
    gain_level <= 8'h03;
    u_ccd_timing_gen.line_shift();
    u_ccd_timing_gen.pulse(PIN_GAIN);
    u_ccd_timing_gen.serial(1, 1'b1);
    chk_word(16'h00C0, 11'h003, 12'h000, 1'b1, 1'b0);
    // two dark packets, each gained by three, then summed at the node
    u_ccd_timing_gen.serial(2, 1'b0);
    u_ccd_timing_gen.pulse(PIN_NODE);
    chk_word(16'h0180, 11'h003, 12'h002, 1'b1, 1'b0);
    u_ccd_timing_gen.serial(25, 1'b1);
    repeat (10) @(posedge core_clk);
    wq.delete();
    // first lit column: about 6046 cycles from drain fall to frame stored is 120 us, >> 2, times three
    u_ccd_timing_gen.serial(1, 1'b1);
    chk_word(16'h005A, 11'h003, 12'h01C, 1'b0, 1'b0);
    u_ccd_timing_gen.serial(971, 1'b1);
    repeat (10) @(posedge core_clk);
    wq.delete();
    u_ccd_timing_gen.serial(4, 1'b1);
    for (i = 0; i < 4; i++) chk_word(16'h00C0, 11'h003, 12'h3E8 + i[11:0], 1'b1, 1'b0);
    u_ccd_timing_gen.serial(1, 1'b1);
    chk_word(16'h0000, 11'h003, 12'h3EC, 1'b0, 1'b0);
  endtask : t_gain_sum
  task automatic t_new_line();
    u_ccd_timing_gen.line_shift();
    u_ccd_timing_gen.serial(1, 1'b1);
    chk_word(DARK_LEVEL, 11'h004, 12'h000, 1'b1, 1'b0);
  endtask : t_new_line
  // receiver stalls: buffer and push register hold three, the fourth is lost
  task automatic t_overrun();
    @(posedge core_clk);
    pix_ready <= 1'b0;
    ovr_cnt = 0;
    repeat (4) u_ccd_timing_gen.pulse(PIN_NODE);
    repeat (6) @(posedge core_clk);
    `CHK("overrun pulses", 1, ovr_cnt)
    pix_ready <= 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK("words kept", 3, wq.size())
  endtask : t_overrun

  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_frame();
    t_bad_lines();
    t_gain_sum();
    t_new_line();
    t_overrun();
    stop_test();
  end
endmodule : tb_ccd_readout_seq

bind ccd_readout_seq ccd_readout_seq_chk #(.CLEAR_MIN_CYC(CLEAR_MIN_CYC), .DUMMY_PIXELS(DUMMY_PIXELS))
  u_ccd_readout_seq_chk (.core_clk(core_clk), .srst(srst), .image_gate_phase_b(image_gate_phase_b),
  .node_clear_pulse(node_clear_pulse), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
  .pix_line(pix_line), .pix_col(pix_col), .pix_dark(pix_dark), .pix_invalid(pix_invalid),
  .frame_stored(frame_stored), .integrating(integrating), .sample_overrun(sample_overrun));
